// File: core/report_hold.sv
// Small register store that holds one formatted report byte-wise.
// Assumes writes and reads on the same clock; read data is registered.
`timescale 1ns/1ps
module report_hold #(
    parameter int unsigned DEPTH = 5,
    parameter int unsigned WIDTH = 8
) (
    input wire logic sys_clk, // System clock
    input wire logic ce, // Clock enable
    input wire logic wr_en, // Write whole report
    input wire logic [DEPTH*WIDTH-1:0] wr_data, // Report, byte 0 lowest
    input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Byte index
    output logic [WIDTH-1:0] rd_data // Registered byte
);
    logic [WIDTH-1:0] mem [DEPTH];

    // =========================================================
    // Storage, one generate entry per byte
    for (genvar i = 0; i < DEPTH; i++) begin : g_byte
        always_ff @(posedge sys_clk) begin
            if (ce && wr_en) begin
                mem[i] <= wr_data[i*WIDTH +: WIDTH];
            end
        end
    end

    // Registered read so the output comes from a flop
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // report_hold

// File: core/rf_mouse_usb_report_wakeup.sv
// Receiver-side mouse report formatter, lamp latch, pairing and wakeup.
// Assumes the RF decoder and USB engine sit on sys_clk; pins are synced.
// Function
// [RL1] Composite device, two HID endpoints
// [RL2] Keyboard interface same report both protocols
// [RL3] Apply host lamp byte to lamps
// [RL4] Report ids 1 and 2 reserved
// [RL5] Never send keyboard reports
// [RL6] Mouse report id 3 in byte 0
// [RL7] Five byte report, buttons and XYZ
// [RL8] Remote wakeup supported during suspend
// [RL9] Each wake pulse powers RF and listens
// [RL10] Start wake oscillator before sleeping; code starts it in the cycle rf_power falls
// [RL11] Short window below one packet
// [RL12] Fragment seen opens long window
// [RL13] Complete packet in long window wakes host
// [RL14] Long window timeout returns to sleep
// [RL15] Pair button held accepts new identifier
// [RL16] Id flag makes second byte identifier
// [RL17] Displacements passed unchanged as signed bytes
// [RL18] Each valid packet becomes a report; code drops id packets, packets outside W_AWAKE and mid-report packets
// [RL19] Button bits three to seven zero
// [RL20] Window lengths configurable, short below packet
`timescale 1ns/1ps
module rf_mouse_usb_report_wakeup #(
    parameter int unsigned SHORT_CYC = rf_mouse_pkg::SHORT_LISTEN_CYC,
    parameter int unsigned LONG_CYC = rf_mouse_pkg::LONG_LISTEN_CYC,
    parameter int unsigned PKT_CYC = rf_mouse_pkg::PACKET_LENGTH_CYC
) (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset, high
    input wire logic ce, // Clock enable
    input wire logic pkt_valid, // Decoded packet strobe
    input wire logic pkt_kind, // 0 XY, 1 button/Z
    input wire logic [7:0] pkt_byte0, // X or button status
    input wire logic [7:0] pkt_byte1, // Y or Z or new id
    input wire logic frag_seen, // Packet fragment recognised
    input wire logic usb_suspend, // Bus suspended
    input wire logic lamp_wr, // Host lamp report strobe
    input wire logic [7:0] lamp_byte, // Host lamp byte
    input wire logic wake_pulse_pin, // Periodic wake pin, async
    input wire logic receiver_pair_button, // Pair button pin, async
    input wire logic rpt_ready, // USB engine takes a byte
    output logic rpt_valid, // Report byte valid
    output logic [7:0] rpt_data, // Report byte
    output logic rpt_last, // Last report byte
    output logic [1:0] rpt_endpoint, // Endpoint of report
    output logic [1:0] rpt_interface, // Interface of report
    output logic [2:0] lamps, // Keyboard lamps
    output logic [7:0] mouse_id, // Stored identifier
    output logic rf_power, // RF front end on
    output logic wake_osc_start, // Run wake charge cycle
    output logic remote_wakeup // Resume request pulse
);
    typedef enum logic [2:0] {W_AWAKE, W_SLEEP, W_SHORT, W_LONG, W_WAKE} wake_state_t;
    typedef enum logic [1:0] {T_IDLE, T_FETCH, T_LOAD, T_SEND} tx_state_t;

    // Short window must miss a whole packet, long window must hold one
    if (SHORT_CYC == 0 || SHORT_CYC >= PKT_CYC || LONG_CYC <= PKT_CYC) begin : g_bad_windows
        $error("window lengths unusable"); // see [RL20]
    end

    // =========================================================
    // Pin synchronisers
    logic wake_s1_r, wake_s2_r, wake_s3_r, pair_s1_r, pair_s2_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {wake_s1_r, wake_s2_r, wake_s3_r, pair_s1_r, pair_s2_r} <= 5'h00;
        end else if (ce) begin
            wake_s1_r <= wake_pulse_pin;
            wake_s2_r <= wake_s1_r;
            wake_s3_r <= wake_s2_r;
            pair_s1_r <= receiver_pair_button;
            pair_s2_r <= pair_s1_r;
        end
    end
    logic wake_rise;
    assign wake_rise = wake_s2_r & ~wake_s3_r;

    // =========================================================
    // Lamps follow each host output byte
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lamps <= rf_mouse_pkg::LAMP_RESET;
        end else if (ce && lamp_wr) begin
            lamps <= lamp_byte[2:0]; // see [RL3]
        end
    end

    // =========================================================
    // Pairing: id flag with button held stores the new identifier
    logic id_pkt;
    assign id_pkt = pkt_valid && (pkt_kind == rf_mouse_pkg::PKT_BUTTON_Z)
        && pkt_byte0[rf_mouse_pkg::BTN_ID_BIT];
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mouse_id <= rf_mouse_pkg::MOUSE_ID_RESET;
        end else if (ce && id_pkt && pair_s2_r) begin
            mouse_id <= pkt_byte1; // see [RL15] see [RL16]
        end
    end

    // =========================================================
    // Wakeup state machine with duty-cycled listening
    wake_state_t ws_r;
    logic [$clog2(LONG_CYC+1)-1:0] win_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ws_r <= W_AWAKE;
            win_cnt_r <= '0;
        end else if (ce) begin
            unique case (ws_r)
                W_AWAKE: begin
                    if (usb_suspend) begin
                        ws_r <= W_SLEEP; // see [RL8]
                    end
                end
                W_SLEEP: begin
                    if (!usb_suspend) begin
                        ws_r <= W_AWAKE;
                    end else if (wake_rise) begin
                        ws_r <= W_SHORT; // see [RL9]
                        win_cnt_r <= '0;
                    end
                end
                W_SHORT: begin
                    win_cnt_r <= win_cnt_r + 1'b1;
                    if (frag_seen || pkt_valid) begin
                        ws_r <= W_LONG; // see [RL12]
                        win_cnt_r <= '0;
                    end else if (win_cnt_r == ($bits(win_cnt_r))'(SHORT_CYC - 1)) begin
                        ws_r <= W_SLEEP; // see [RL11]
                    end
                end
                W_LONG: begin
                    win_cnt_r <= win_cnt_r + 1'b1;
                    if (pkt_valid) begin
                        ws_r <= W_WAKE; // see [RL13]
                    end else if (win_cnt_r == ($bits(win_cnt_r))'(LONG_CYC - 1)) begin
                        ws_r <= W_SLEEP; // see [RL14]
                    end
                end
                W_WAKE: begin
                    ws_r <= W_AWAKE;
                end
                default: ws_r <= W_AWAKE;
            endcase
        end
    end

    // Outputs registered from the current state, so they lag ws_r one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rf_power <= 1'b1;
            wake_osc_start <= 1'b0;
            remote_wakeup <= 1'b0;
        end else if (ce) begin
            rf_power <= (ws_r == W_AWAKE) || (ws_r == W_SHORT) || (ws_r == W_LONG);
            // Oscillator runs outside W_AWAKE and W_WAKE, starting on the same cycle rf_power falls
            wake_osc_start <= (ws_r != W_AWAKE) && (ws_r != W_WAKE); // see [RL10]
            remote_wakeup <= (ws_r == W_WAKE); // see [RL13]
        end
    end

    // =========================================================
    // Report building; only mouse reports ever leave
    logic [8*rf_mouse_pkg::REPORT_BYTES-1:0] cur_rpt_r;
    logic [7:0] x_r, y_r, z_r, btn_r;
    logic build_r;
    logic rpt_pkt;
    tx_state_t tx_r;
    logic [2:0] idx_r;
    logic [7:0] hold_data;
    // Packets while suspended go to wakeup, not to the host
    assign rpt_pkt = pkt_valid && (ws_r == W_AWAKE) && !id_pkt; // see [RL18]
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {x_r, y_r, z_r, btn_r} <= 32'h0000_0000;
            build_r <= 1'b0;
        end else if (ce) begin
            build_r <= 1'b0;
            // A second packet during the build cycle would rewrite a report in flight
            if (rpt_pkt && tx_r == T_IDLE && !build_r) begin
                build_r <= 1'b1;
                if (pkt_kind == rf_mouse_pkg::PKT_XY) begin
                    x_r <= pkt_byte0; // see [RL17]
                    y_r <= pkt_byte1;
                    z_r <= 8'h00;
                end else begin
                    btn_r <= {5'h00, pkt_byte0[2:0]}; // see [RL7] see [RL19]
                    x_r <= 8'h00;
                    y_r <= 8'h00;
                    z_r <= pkt_byte1;
                end
            end
        end
    end
    // Byte 0 always the mouse report id 3; ids 1 and 2 never generated
    assign cur_rpt_r = {z_r, y_r, x_r, btn_r, rf_mouse_pkg::MOUSE_REPORT_ID}; // see [RL6] see [RL4]

    report_hold #(.DEPTH(rf_mouse_pkg::REPORT_BYTES), .WIDTH(8)) u_hold (
        .sys_clk(sys_clk),
        .ce(ce),
        .wr_en(build_r),
        .wr_data(cur_rpt_r),
        .rd_addr(idx_r),
        .rd_data(hold_data)
    );

    // =========================================================
    // Byte streaming to the USB engine on the mouse endpoint
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_r <= T_IDLE;
            idx_r <= 3'h0;
            rpt_valid <= 1'b0;
            rpt_data <= 8'h00;
            rpt_last <= 1'b0;
            rpt_endpoint <= rf_mouse_pkg::MOUSE_ENDPOINT; // see [RL1]
            // Keyboard interface carries no traffic, so its format is never at risk
            rpt_interface <= rf_mouse_pkg::MOUSE_INTERFACE; // see [RL5] see [RL2]
        end else if (ce) begin
            unique case (tx_r)
                T_IDLE: begin
                    if (build_r) begin
                        tx_r <= T_FETCH;
                        idx_r <= 3'h0;
                    end
                end
                // Registered read needs one cycle after idx_r settles
                T_FETCH: begin
                    tx_r <= T_LOAD;
                end
                T_LOAD: begin
                    rpt_valid <= 1'b1;
                    rpt_data <= hold_data;
                    rpt_last <= (idx_r == 3'(rf_mouse_pkg::REPORT_BYTES - 1));
                    tx_r <= T_SEND;
                end
                T_SEND: begin
                    if (rpt_ready) begin
                        rpt_valid <= 1'b0;
                        rpt_last <= 1'b0;
                        if (rpt_last) begin
                            tx_r <= T_IDLE;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                            tx_r <= T_FETCH;
                        end
                    end
                end
                default: tx_r <= T_IDLE;
            endcase
        end
    end

    // =========================================================
    // Checks
    property p_short_ends;
        @(posedge sys_clk) disable iff (srst)
        (ce && ws_r == W_SHORT && !frag_seen && !pkt_valid
         && win_cnt_r == ($bits(win_cnt_r))'(SHORT_CYC - 1)) |=> ws_r == W_SLEEP;
    endproperty
    a_short_ends: assert property (p_short_ends) else $error("short window overran"); // see [RL11]
    property p_frag_long;
        @(posedge sys_clk) disable iff (srst)
        (ce && ws_r == W_SHORT && frag_seen) |=> ws_r == W_LONG;
    endproperty
    a_frag_long: assert property (p_frag_long) else $error("no long window"); // see [RL12]
    property p_wake;
        @(posedge sys_clk) disable iff (srst)
        (ce && ws_r == W_LONG && pkt_valid) ##1 ce |=> remote_wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("no remote wakeup"); // see [RL13]
    property p_noise;
        @(posedge sys_clk) disable iff (srst)
        (ws_r == W_LONG && $past(ws_r) == W_LONG && ce && !pkt_valid
         && win_cnt_r == ($bits(win_cnt_r))'(LONG_CYC - 1)) |=> ws_r == W_SLEEP ##1 !remote_wakeup;
    endproperty
    a_noise: assert property (p_noise) else $error("noise woke host"); // see [RL14]
    property p_pair;
        @(posedge sys_clk) disable iff (srst)
        (ce && id_pkt && pair_s2_r) |=> mouse_id == $past(pkt_byte1);
    endproperty
    a_pair: assert property (p_pair) else $error("id not stored"); // see [RL15]
    property p_nopair;
        @(posedge sys_clk) disable iff (srst)
        (!pair_s2_r) |=> $stable(mouse_id);
    endproperty
    a_nopair: assert property (p_nopair) else $error("id changed unpaired"); // see [RL15]
    property p_id3;
        @(posedge sys_clk) disable iff (srst)
        (rpt_valid && !$past(rpt_valid) && idx_r == 3'h0)
            |-> rpt_data == rf_mouse_pkg::MOUSE_REPORT_ID;
    endproperty
    a_id3: assert property (p_id3) else $error("bad report id"); // see [RL6]
    property p_lamp;
        @(posedge sys_clk) disable iff (srst)
        (ce && lamp_wr) |=> lamps == $past(lamp_byte[2:0]);
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp not applied"); // see [RL3]
    property p_osc;
        @(posedge sys_clk) disable iff (srst)
        (ws_r == W_SHORT) |-> wake_osc_start;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator idle"); // see [RL10]
endmodule // rf_mouse_usb_report_wakeup

// File: shared/rf_mouse_pkg.sv
// Constants shared by the mouse report formatter and wakeup logic.
// Assumes a 200 MHz system clock; all times are in nanoseconds.
package rf_mouse_pkg;
    // =========================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned PACKET_LENGTH_TIME_NS = 4000;
    localparam int unsigned SHORT_LISTEN_WINDOW_NS = 1000;
    localparam int unsigned LONG_LISTEN_WINDOW_NS = 12000;
    // Short window and packet length round down, long window rounds up
    localparam int unsigned PACKET_LENGTH_CYC = PACKET_LENGTH_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned SHORT_LISTEN_CYC = SHORT_LISTEN_WINDOW_NS / CLK_PERIOD_NS;
    localparam int unsigned LONG_LISTEN_CYC =
        (LONG_LISTEN_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // =========================================================
    // Report layout
    localparam int unsigned REPORT_BYTES = 5;
    localparam logic [7:0] MOUSE_REPORT_ID = 8'h03;
    localparam logic [7:0] KBD_POWER_REPORT_ID = 8'h01;
    localparam logic [7:0] KBD_MEDIA_REPORT_ID = 8'h02;
    localparam logic [1:0] MOUSE_INTERFACE = 2'h1;
    localparam logic [1:0] KBD_INTERFACE = 2'h0;
    localparam logic [1:0] MOUSE_ENDPOINT = 2'h2;
    localparam logic [1:0] KBD_ENDPOINT = 2'h1;
    localparam int unsigned BTN_LEFT_BIT = 0;
    localparam int unsigned BTN_RIGHT_BIT = 1;
    localparam int unsigned BTN_MIDDLE_BIT = 2;
    localparam int unsigned BTN_ID_BIT = 3;
    localparam logic [2:0] LAMP_RESET = 3'h0;
    localparam logic [7:0] MOUSE_ID_RESET = 8'h00;
    // =========================================================
    // Packet kinds from the RF decoder
    typedef enum logic {PKT_XY, PKT_BUTTON_Z} pkt_kind_t;
endpackage

// File: verification/tb_top.sv
// Scenario bench for the mouse report formatter, lamp latch, pairing and wakeup.
// Assumes shortened window parameters; the host model paces the report stream.
`timescale 1ns/1ps
module tb_top;
    localparam int SHORT = 4;
    localparam int LONG = 20;
    logic sys_clk, srst, ce, pkt_valid, pkt_kind, frag_seen, usb_suspend, lamp_wr;
    logic wake_pulse_pin, receiver_pair_button, rpt_ready, stall;
    logic [7:0] pkt_byte0, pkt_byte1, lamp_byte, rpt_data, mouse_id;
    logic rpt_valid, rpt_last, rf_power, wake_osc_start, remote_wakeup;
    logic [1:0] rpt_endpoint, rpt_interface;
    logic [2:0] lamps;
    logic [39:0] rx_report;
    int rx_reports, bad_frames, n_mismatch, checked, wake_cnt, cycles, base;

    rf_mouse_usb_report_wakeup #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .PKT_CYC(8))
        rf_mouse_usb_report_wakeup_i (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_byte0(pkt_byte0),
        .pkt_byte1(pkt_byte1), .frag_seen(frag_seen), .usb_suspend(usb_suspend),
        .lamp_wr(lamp_wr), .lamp_byte(lamp_byte), .wake_pulse_pin(wake_pulse_pin),
        .receiver_pair_button(receiver_pair_button), .rpt_ready(rpt_ready),
        .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_last(rpt_last),
        .rpt_endpoint(rpt_endpoint), .rpt_interface(rpt_interface), .lamps(lamps),
        .mouse_id(mouse_id), .rf_power(rf_power), .wake_osc_start(wake_osc_start),
        .remote_wakeup(remote_wakeup));
    usb_host_model usb_host_model_i (.sys_clk(sys_clk), .stall(stall),
        .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_last(rpt_last),
        .rpt_endpoint(rpt_endpoint), .rpt_interface(rpt_interface),
        .rpt_ready(rpt_ready), .rx_report(rx_report), .rx_reports(rx_reports),
        .bad_frames(bad_frames));
    // =====================================================================
    // Clock, wakeup pulse counter and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (remote_wakeup === 1'b1) wake_cnt++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // =====================================================================
    // Shared helpers: inputs move 1 ns after the rising edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic send_pkt(input logic kind, input logic [7:0] a, input logic [7:0] b);
        pkt_kind = kind;
        pkt_byte0 = a;
        pkt_byte1 = b;
        pkt_valid = 1'b1;
        step();
        pkt_valid = 1'b0;
    endtask
    task automatic expect_report(input logic kind, input logic [7:0] a,
        input logic [7:0] b, input logic [39:0] exp);
        base = rx_reports;
        send_pkt(kind, a, b);
        for (int i = 0; i < 100 && rx_reports == base; i++) step();
        chk(40'(rx_reports - base), 40'h1, "report count");
        chk(rx_report, exp, "report bytes");
        chk(40'(bad_frames), 40'h0, "framing or route");
        step(2);
    endtask
    task automatic wake_and_listen();
        wake_pulse_pin = 1'b1;
        step(3);
        wake_pulse_pin = 0;
        for (int i = 0; i < 8 && rf_power !== 1'b1; i++) step();
        chk(40'(rf_power), 40'h1, "rf on at wake");
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_reports();
        chk({rpt_valid, rpt_endpoint, rpt_interface, lamps, mouse_id, remote_wakeup},
            {1'b0, 2'h2, 2'h1, 3'h0, 8'h00, 1'b0}, "reset state");
        stall = 1'b1;
        expect_report(1'b0, 8'h81, 8'h7f, {8'h00, 8'h7f, 8'h81, 8'h00, 8'h03});
        stall = 1'b0;
        expect_report(1'b1, 8'hf7, 8'h80, {8'h80, 8'h00, 8'h00, 8'h07, 8'h03});
        expect_report(1'b1, 8'h02, 8'h01, {8'h01, 8'h00, 8'h00, 8'h02, 8'h03});
        // Mid-stream packet is dropped; button state persists over XY packets
        stall = 1'b1;
        base = rx_reports;
        send_pkt(1'b0, 8'h11, 8'h22);
        step(4);
        send_pkt(1'b0, 8'h33, 8'h44);
        step(120);
        chk(40'(rx_reports - base), 40'h1, "mid-stream drop");
        chk(rx_report, {8'h00, 8'h22, 8'h11, 8'h02, 8'h03}, "first kept");
        stall = 1'b0;
        $display("Test reports done");
    endtask
    task automatic t_lamps();
        ce = 1'b0;
        lamp_byte = 8'h05;
        lamp_wr = 1'b1;
        step();
        lamp_wr = 1'b0;
        step(2);
        chk(40'(lamps), 40'h0, "lamps frozen by ce");
        ce = 1'b1;
        lamp_byte = 8'hfd;
        lamp_wr = 1'b1;
        step();
        chk(40'(lamps), 40'h5, "lamps first byte");
        lamp_byte = 8'h02;
        step();
        lamp_wr = 1'b0;
        chk(40'(lamps), 40'h2, "lamps second byte");
        $display("Test lamps done");
    endtask
    task automatic t_pair();
        base = rx_reports;
        receiver_pair_button = 1'b1;
        step(4);
        send_pkt(1'b1, 8'h08, 8'h5a);
        step(4);
        chk(40'(mouse_id), 40'h5a, "id stored");
        receiver_pair_button = 1'b0;
        step(4);
        send_pkt(1'b1, 8'h08, 8'h33);
        step(20);
        chk(40'(mouse_id), 40'h5a, "id kept unpaired");
        chk(40'(rx_reports - base), 40'h0, "id packets silent");
        $display("Test pairing done");
    endtask
    task automatic t_wakeup();
        base = wake_cnt;
        usb_suspend = 1'b1;
        step(4);
        chk({wake_osc_start, rf_power}, 2'h2, "sleep entry");
        wake_and_listen();
        step(SHORT + 3);
        chk(40'(rf_power), 40'h0, "short window ends");
        wake_and_listen();
        frag_seen = 1'b1;
        step();
        frag_seen = 1'b0;
        step(LONG + 6);
        chk({rf_power, 32'(wake_cnt - base)}, 40'h0, "noise rejected");
        wake_and_listen();
        frag_seen = 1'b1;
        step();
        frag_seen = 1'b0;
        base = rx_reports;
        step(SHORT + 6);
        chk(40'(rf_power), 40'h1, "long window held");
        send_pkt(1'b0, 8'h01, 8'h02);
        step(6);
        chk(40'(wake_cnt), 40'h1, "host woken once");
        chk(40'(rx_reports - base), 40'h0, "no report in suspend");
        usb_suspend = 1'b0;
        step(4);
        $display("Test wakeup done");
    endtask
    // =====================================================================
    // Closing report, reached from the main sequence or the hang guard
    task automatic print_verdict();
        $display("Counts: checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // =====================================================================
    // Main sequence: reset held ten cycles, then each scenario in turn
    initial begin
        {srst, ce, pkt_valid, pkt_kind, frag_seen, usb_suspend, lamp_wr} = 7'h60;
        {wake_pulse_pin, receiver_pair_button, stall} = 3'h0;
        {pkt_byte0, pkt_byte1, lamp_byte} = '0;
        {n_mismatch, checked, wake_cnt, cycles} = '0;
        srst = 1'b1;
        step(10);
        srst = 1'b0;
        step();
        t_reports();
        t_lamps();
        t_pair();
        t_wakeup();
        print_verdict();
    end
endmodule // tb_top

// File: verification/usb_host_model.sv
// Behavioural host side of the mouse report stream: paces ready, rebuilds reports.
// Assumes the formatter's byte handshake on sys_clk; no USB protocol engine here.
`timescale 1ns/1ps
module usb_host_model (
    input wire logic sys_clk, // System clock
    input wire logic stall, // Slow host when high
    input wire logic rpt_valid, // Report byte valid
    input wire logic [7:0] rpt_data, // Report byte
    input wire logic rpt_last, // Last report byte
    input wire logic [1:0] rpt_endpoint, // Endpoint of report
    input wire logic [1:0] rpt_interface, // Interface of report
    output logic rpt_ready, // Byte taken
    output logic [39:0] rx_report, // Last whole report
    output int rx_reports, // Reports received
    output int bad_frames // Misframed or misrouted bytes
);
    logic [39:0] acc_r;
    int idx_r;
    int gap_r;
    // =====================================================================
    // Start idle: a real host grants nothing before enumeration
    initial begin
        rpt_ready = 1'b0;
        rx_report = '0;
        rx_reports = 0;
        bad_frames = 0;
        acc_r = '0;
        idx_r = 0;
        gap_r = 0;
    end
    // =====================================================================
    // Slow host grants one cycle in three, so bytes must stand while waiting
    always @(posedge sys_clk) begin
        gap_r = (gap_r + 1) % 3;
        rpt_ready <= #1 !stall || (gap_r == 1);
        if (rpt_valid === 1'b1 && rpt_ready === 1'b1) begin
            acc_r[idx_r*8 +: 8] = rpt_data;
            if (rpt_endpoint !== 2'h2 || rpt_interface !== 2'h1) bad_frames++;
            if (rpt_last === 1'b1) begin
                if (idx_r != 4) bad_frames++;
                rx_report = acc_r;
                rx_reports++;
                idx_r = 0;
            end else begin
                if (idx_r == 4) bad_frames++;
                idx_r = (idx_r + 1) % 5;
            end
        end
    end
endmodule // usb_host_model
